// file: design/hpg_pkg.sv
// Package for the high ports GPIO block: addresses, reset values, field positions
// What this block does
// R1: With memory interface on high ports, software keeps low-port select at zero.
// R2: During an off-chip data move, the memory interface drives pins, ignoring latches.
// R3: Memory activity keeps output modes; external reads release the data-bus drivers.
// R4: Mode bits 7 and 6 pick push-pull or open-drain for port 7 nibbles.
// R5: Mode bits 5 and 4 pick push-pull or open-drain for port 6 nibbles.
// R6: Mode bits 3 and 2 pick push-pull or open-drain for port 5 nibbles.
// R7: Mode bits 1 and 0 pick push-pull or open-drain for port 4 nibbles.
// R8: Output-mode register resets to zero, all open-drain, at address b5.
// R9: Latch zero drives low; one drives high in push-pull, else undriven.
// R10: Data register reads return live pin levels, not the latch.
// R11: All four data latches reset to all ones at their own addresses.
// R12: Port 4 pins 7, 6, 5 carry write strobe, read strobe, address latch.
// R13: Port 5 carries upper address byte in non-multiplexed mode.
// R14: Port 6 carries upper address multiplexed, lower address non-multiplexed.
// R15: Port 7 carries address/data multiplexed, data non-multiplexed.
// R16: A pin driving low has its weak pull-up switched off.
// R17: For input use, software sets open-drain and writes one to the bit.
// R18: Writes land on the completing clock edge; reads see synchronised pins.
package hpg_pkg;
  localparam logic [7:0] HPG_ADDR_PORT4 = 8'h84;
  localparam logic [7:0] HPG_ADDR_PORT5 = 8'h85;
  localparam logic [7:0] HPG_ADDR_PORT6 = 8'h86;
  localparam logic [7:0] HPG_ADDR_PORT7 = 8'h96;
  localparam logic [7:0] HPG_ADDR_MODE = 8'hb5;
  localparam logic [7:0] HPG_LATCH_RST = 8'hff;
  localparam logic [7:0] HPG_MODE_RST  = 8'h00;
  localparam int         HPG_WR_BIT    = 7;
  localparam int         HPG_RD_BIT    = 6;
  localparam int         HPG_ALE_BIT   = 5;
endpackage

// file: design/hpg_gpio.sv
// High ports 4 to 7 GPIO with external memory interface override
`timescale 1ns/1ns
`default_nettype none
module hpg_gpio
  import hpg_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  output logic             sfr_hit,
  input  wire logic        mem_on_high,
  input  wire logic        mem_active,
  input  wire logic        mem_read,
  input  wire logic        mem_muxed,
  input  wire logic        mem_wr_n,
  input  wire logic        mem_rd_n,
  input  wire logic        mem_ale,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  input  wire logic [31:0] pin_in,
  output logic      [31:0] pin_out,
  output logic      [31:0] pin_oe,
  output logic      [31:0] pin_pullup_en,
  input  wire logic        weak_pullup_dis
);
  logic [7:0]  latch_r [4];
  logic [7:0]  mode_r;
  logic [31:0] sync1_r;
  logic [31:0] sync2_r;
  logic [31:0] latch_flat;
  logic [31:0] mem_val;
  logic [31:0] mem_own;
  logic [31:0] pp_mask;
  logic [31:0] out_val;
  logic [31:0] drive;
  logic [7:0]  port_addr [4];
  logic [3:0]  port_hit;
  logic        mode_hit;
  logic        mem_go;
  logic        data_bus_rd;

  assign port_addr[0] = HPG_ADDR_PORT4;
  assign port_addr[1] = HPG_ADDR_PORT5;
  assign port_addr[2] = HPG_ADDR_PORT6;
  assign port_addr[3] = HPG_ADDR_PORT7;
  assign mode_hit = (sfr_addr == HPG_ADDR_MODE);
  assign mem_go   = mem_on_high && mem_active;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_port
      assign port_hit[g]             = (sfr_addr == port_addr[g]);
      assign latch_flat[g*8 +: 8]    = latch_r[g];
      // R4 R5 R6 R7: nibble mode bits
      assign pp_mask[g*8 +: 4]       = {4{mode_r[2*g]}};
      assign pp_mask[g*8+4 +: 4]     = {4{mode_r[2*g+1]}};
      // R18: write on completing edge
      always_ff @(posedge clk) begin
        if (!nrst) begin
          // R11: latches reset high
          latch_r[g] <= HPG_LATCH_RST;
        end else if (sfr_wr && port_hit[g]) begin
          latch_r[g] <= sfr_wdata;
        end
      end
    end
  endgenerate

  // R8: mode register reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      mode_r <= HPG_MODE_RST;
    end else if (sfr_wr && mode_hit) begin
      mode_r <= sfr_wdata;
    end
  end

  // R18: two-stage pin synchroniser
  // Only the second stage is read, the first may still be settling
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync1_r <= '1;
      sync2_r <= '1;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
    end
  end

  // R12 R13 R14 R15: memory interface pin values
  assign mem_val[4:0]        = latch_r[0][4:0];
  assign mem_val[HPG_WR_BIT]  = mem_wr_n;
  assign mem_val[HPG_RD_BIT]  = mem_rd_n;
  assign mem_val[HPG_ALE_BIT] = mem_ale;
  assign mem_val[15:8]       = mem_muxed ? latch_r[1] : mem_addr[15:8];
  assign mem_val[23:16]      = mem_muxed ? mem_addr[15:8] : mem_addr[7:0];
  assign mem_val[31:24]      = (mem_muxed && mem_ale) ? mem_addr[7:0] : mem_wdata;
  // Port 5 is spare in multiplexed mode; port 4 low pins always stay GPIO
  assign mem_own = {8'hff, 8'hff, {8{!mem_muxed}}, 8'he0};

  // R2: memory interface overrides latches
  assign out_val = mem_go ? ((mem_val & mem_own) | (latch_flat & ~mem_own)) : latch_flat;
  // R3: data phase of an external read
  assign data_bus_rd = mem_go && mem_read && !(mem_muxed && mem_ale);
  // R9: low drives, high drives only in push-pull; R3 keeps modes
  assign drive = ~out_val | (out_val & pp_mask);
  always_comb begin
    pin_out = out_val;
    pin_oe  = drive;
    // R3: external read releases data bus
    if (data_bus_rd) begin
      pin_oe[31:24] = 8'h00;
    end
  end
  // R16: pull-up off on pins driven low
  assign pin_pullup_en = ~(pin_oe & ~pin_out) & {32{!weak_pullup_dis}};

  // R10: reads return pin levels
  always_comb begin
    sfr_rdata = 8'h00;
    sfr_hit   = mode_hit | (|port_hit);
    if (mode_hit) begin
      sfr_rdata = mode_r;
    end
    for (int i = 0; i < 4; i++) begin
      if (port_hit[i]) begin
        sfr_rdata = sync2_r[i*8 +: 8];
      end
    end
  end

  // Read data is combinational on the address, so the strobe is not needed
  logic unused_rd;
  assign unused_rd = sfr_rd;

  // R8: mode register resets to zero
  mode_reset_a: assert property (@(posedge clk) // R8
    !nrst
    |=> mode_r == HPG_MODE_RST)
    else $error("mode register not cleared by reset");
  // R11: port 7 latch resets to ones
  latch_reset_a: assert property (@(posedge clk) // R11
    !nrst
    |=> latch_r[3] == HPG_LATCH_RST)
    else $error("port latch not set by reset");
  // R11: port 4 latch reset
  port4_reset_a: assert property (@(posedge clk) // R11
    !nrst
    |=> latch_r[0] == HPG_LATCH_RST)
    else $error("port 4 latch not set by reset");

  // R18: write lands next edge
  latch_write_a: assert property (@(posedge clk) disable iff (!nrst) // R18
    sfr_wr && sfr_addr == HPG_ADDR_PORT5
    |=> latch_r[1] == $past(sfr_wdata))
    else $error("port 5 write not stored");
  // R18: port 4 write
  port4_write_a: assert property (@(posedge clk) disable iff (!nrst) // R18
    sfr_wr && sfr_addr == HPG_ADDR_PORT4
    |=> latch_r[0] == $past(sfr_wdata))
    else $error("port 4 write not stored");
  // R18: port 7 write
  port7_write_a: assert property (@(posedge clk) disable iff (!nrst) // R18
    sfr_wr && sfr_addr == HPG_ADDR_PORT7
    |=> latch_r[3] == $past(sfr_wdata))
    else $error("port 7 write not stored");
  // R18: mode register write
  mode_write_a: assert property (@(posedge clk) disable iff (!nrst) // R18
    sfr_wr && sfr_addr == HPG_ADDR_MODE
    |=> mode_r == $past(sfr_wdata))
    else $error("mode register write not stored");

  // R10: read returns synced pin
  pin_read_a: assert property (@(posedge clk) disable iff (!nrst) // R10
    sfr_addr == HPG_ADDR_PORT4
    |-> sfr_rdata == $past(pin_in[7:0], 2))
    else $error("port 4 read not pin level");
  // R10: port 5 read
  port5_read_a: assert property (@(posedge clk) disable iff (!nrst) // R10
    sfr_addr == HPG_ADDR_PORT5
    |-> sfr_rdata == $past(pin_in[15:8], 2))
    else $error("port 5 read not pin level");
  // R10: port 7 read
  port7_read_a: assert property (@(posedge clk) disable iff (!nrst) // R10
    sfr_addr == HPG_ADDR_PORT7
    |-> sfr_rdata == $past(pin_in[31:24], 2))
    else $error("port 7 read not pin level");
  // R8: mode register reads back
  mode_read_a: assert property (@(posedge clk) disable iff (!nrst) // R8
    sfr_addr == HPG_ADDR_MODE
    |-> sfr_hit && sfr_rdata == mode_r)
    else $error("mode register read wrong");
  // R18: unmapped address reads zero
  miss_read_a: assert property (@(posedge clk) disable iff (!nrst) // R18
    !sfr_hit
    |-> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");

  // R9: open-drain one not driven
  od_release_a: assert property (@(posedge clk) disable iff (!nrst) // R9
    !mem_go && !mode_r[6] && latch_r[3][0]
    |-> !pin_oe[24])
    else $error("open-drain high pin driven");
  // R9: latch zero drives low
  low_drive_a: assert property (@(posedge clk) disable iff (!nrst) // R9
    !mem_go && !latch_r[0][7]
    |-> pin_oe[7] && !pin_out[7])
    else $error("latch zero not driven low");

  // R7: port 4 low nibble mode
  port4_low_mode_a: assert property (@(posedge clk) disable iff (!nrst) // R7
    !mem_go && mode_r[0]
    |-> pin_oe[3:0] == 4'hf)
    else $error("port 4 low nibble not push-pull");
  // R7: port 4 high nibble mode
  port4_high_mode_a: assert property (@(posedge clk) disable iff (!nrst) // R7
    !mem_go && mode_r[1]
    |-> pin_oe[7:4] == 4'hf)
    else $error("port 4 high nibble not push-pull");
  // R6: port 5 low nibble mode
  port5_low_mode_a: assert property (@(posedge clk) disable iff (!nrst) // R6
    !mem_go && mode_r[2]
    |-> pin_oe[11:8] == 4'hf)
    else $error("port 5 low nibble not push-pull");
  // R6: port 5 high nibble mode
  port5_high_mode_a: assert property (@(posedge clk) disable iff (!nrst) // R6
    !mem_go && mode_r[3]
    |-> pin_oe[15:12] == 4'hf)
    else $error("port 5 high nibble not push-pull");
  // R5: port 6 low nibble mode
  port6_low_mode_a: assert property (@(posedge clk) disable iff (!nrst) // R5
    !mem_go && mode_r[4]
    |-> pin_oe[19:16] == 4'hf)
    else $error("port 6 low nibble not push-pull");
  // R5: port 6 high nibble mode
  port6_high_mode_a: assert property (@(posedge clk) disable iff (!nrst) // R5
    !mem_go && mode_r[5]
    |-> pin_oe[23:20] == 4'hf)
    else $error("port 6 high nibble not push-pull");
  // R4: port 7 low nibble mode
  port7_low_mode_a: assert property (@(posedge clk) disable iff (!nrst) // R4
    !mem_go && mode_r[6]
    |-> pin_oe[27:24] == 4'hf)
    else $error("port 7 low nibble not push-pull");
  // R4: port 7 high nibble mode
  port7_high_mode_a: assert property (@(posedge clk) disable iff (!nrst) // R4
    !mem_go && mode_r[7]
    |-> pin_oe[31:28] == 4'hf)
    else $error("port 7 high nibble not push-pull");

  // R12: write strobe follows interface
  wr_strobe_a: assert property (@(posedge clk) disable iff (!nrst) // R12
    mem_go
    |-> pin_out[HPG_WR_BIT] == mem_wr_n)
    else $error("write strobe not from memory interface");
  // R12: read strobe follows interface
  rd_strobe_a: assert property (@(posedge clk) disable iff (!nrst) // R12
    mem_go
    |-> pin_out[HPG_RD_BIT] == mem_rd_n)
    else $error("read strobe not from memory interface");
  // R12: address latch strobe
  ale_strobe_a: assert property (@(posedge clk) disable iff (!nrst) // R12
    mem_go
    |-> pin_out[HPG_ALE_BIT] == mem_ale)
    else $error("address latch strobe not from memory interface");
  // R13: port 5 upper address
  port5_addr_a: assert property (@(posedge clk) disable iff (!nrst) // R13
    mem_go && !mem_muxed
    |-> pin_out[15:8] == mem_addr[15:8])
    else $error("port 5 not upper address");
  // R14: port 6 multiplexed address
  port6_mux_a: assert property (@(posedge clk) disable iff (!nrst) // R14
    mem_go && mem_muxed
    |-> pin_out[23:16] == mem_addr[15:8])
    else $error("port 6 not upper address");
  // R14: port 6 non-multiplexed address
  port6_demux_a: assert property (@(posedge clk) disable iff (!nrst) // R14
    mem_go && !mem_muxed
    |-> pin_out[23:16] == mem_addr[7:0])
    else $error("port 6 not lower address");
  // R15: port 7 address phase
  port7_addr_a: assert property (@(posedge clk) disable iff (!nrst) // R15
    mem_go && mem_muxed && mem_ale
    |-> pin_out[31:24] == mem_addr[7:0])
    else $error("port 7 not address in address phase");
  // R15: port 7 data phase
  port7_data_a: assert property (@(posedge clk) disable iff (!nrst) // R15
    mem_go && !mem_ale
    |-> pin_out[31:24] == mem_wdata)
    else $error("port 7 not data in data phase");

  // R3: read releases data bus
  rd_release_a: assert property (@(posedge clk) disable iff (!nrst) // R3
    mem_go && mem_read && !mem_muxed
    |-> pin_oe[31:24] == 8'h00)
    else $error("data bus driven during external read");
  // R3: interface leaves modes alone
  mode_kept_a: assert property (@(posedge clk) disable iff (!nrst) // R3
    mem_go && !(sfr_wr && mode_hit)
    |=> mode_r == $past(mode_r))
    else $error("output mode changed by memory activity");

  // R16: no pull-up when driving low
  pullup_off_a: assert property (@(posedge clk) disable iff (!nrst) // R16
    pin_oe[16] && !pin_out[16]
    |-> !pin_pullup_en[16])
    else $error("pull-up on while driving low");
  // R16: global pull-up disable
  pullup_dis_a: assert property (@(posedge clk) disable iff (!nrst) // R16
    weak_pullup_dis
    |-> pin_pullup_en == 32'h0)
    else $error("pull-up on while globally disabled");
endmodule
`default_nettype wire

// file: tb/hpg_pins.sv
// Pin model: resolves the high-port wires from block drivers, pull-ups and outside devices
`timescale 1ns/1ns
`default_nettype none
module hpg_pins (
  input  wire logic [31:0] pin_out,
  input  wire logic [31:0] pin_oe,
  input  wire logic [31:0] pin_pullup_en,
  input  wire logic [31:0] ext_oe,
  input  wire logic [31:0] ext_val,
  output logic      [31:0] pin_in
);
  wire logic [31:0] idle_w = ~pin_oe & ~ext_oe;
  // released pins
  // A floating pin without pull-up shows the inverse of pin_out, never a kind guess
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val)
                | (idle_w & (pin_pullup_en | ~pin_out));
endmodule
`default_nettype wire

// file: tb/high_ports_gpio_with_memory_override_tb.sv
// Testbench: registers, output modes, pin reads and memory override of the high ports
`timescale 1ns/1ns
`default_nettype none
module high_ports_gpio_with_memory_override_tb;
  import hpg_pkg::*;
  logic        clk = 0, nrst = 0, wr = 0, on = 0, act = 0, erd = 0, mux = 0, ale = 0;
  logic        wpd = 0, hit;
  logic [7:0]  a = 0, wd = 0, rd, ewd = 0;
  logic [15:0] ea = 0;
  logic [31:0] xoe = 0, xv = 0, pin_in, pin_out, pin_oe, pu;
  int          err_count = 0, checks = 0, cyc = 0;
  hpg_gpio uut (.clk(clk), .nrst(nrst), .sfr_addr(a), .sfr_wr(wr), .sfr_rd(1'b0),
    .sfr_wdata(wd), .sfr_rdata(rd), .sfr_hit(hit), .mem_on_high(on), .mem_active(act),
    .mem_read(erd), .mem_muxed(mux), .mem_wr_n(erd), .mem_rd_n(~erd), .mem_ale(ale),
    .mem_addr(ea), .mem_wdata(ewd), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup_en(pu), .weak_pullup_dis(wpd));
  hpg_pins pins (.pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pu), .ext_oe(xoe),
    .ext_val(xv), .pin_in(pin_in));
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic w(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk);
    a <= ad;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  // Pin levels pass a two-flop synchroniser before they show
  task automatic rc(input logic [7:0] ad, input logic [7:0] e);
    @(posedge clk);
    a <= ad;
    repeat (3) @(posedge clk);
    #1 chk({24'h0, rd}, {24'h0, e});
  endtask
  task automatic t_reset;
    chk(pin_oe, 32'h0);
    chk(pu, 32'hffffffff);
    rc(HPG_ADDR_MODE, 8'h00);
    rc(HPG_ADDR_PORT4, 8'hff);
    rc(HPG_ADDR_PORT7, 8'hff);
    chk({31'h0, hit}, 32'h1);
    rc(8'h90, 8'h00);
    chk({31'h0, hit}, 32'h0);
  endtask
  task automatic t_modes;
    for (int i = 0; i < 8; i++) begin
      w(HPG_ADDR_MODE, 8'h01 << i);
      chk(pin_oe, 32'hf << (4 * i));
    end
  endtask
  task automatic t_pins;
    w(HPG_ADDR_MODE, 8'h00);
    w(HPG_ADDR_PORT4, 8'h0f);
    chk({pin_oe[7:0], pin_out[7:4], pu[7:0]}, {8'hf0, 4'h0, 8'h0f});
    rc(HPG_ADDR_PORT4, 8'h0f);
    @(posedge clk);
    xoe <= 32'h0000ff00;
    xv <= 32'h00005a00;
    rc(HPG_ADDR_PORT5, 8'h5a);
    @(posedge clk);
    xoe <= 32'h0;
    w(HPG_ADDR_PORT6, 8'h3c);
    w(HPG_ADDR_PORT7, 8'hc3);
    rc(HPG_ADDR_PORT6, 8'h3c);
    rc(HPG_ADDR_PORT7, 8'hc3);
  endtask
  task automatic t_pullup;
    @(posedge clk);
    wpd <= 1'b1;
    @(posedge clk);
    #1 chk(pu, 32'h0);
    @(posedge clk);
    wpd <= 1'b0;
    @(posedge clk);
    #1 chk(pu[7:0], 32'h0f);
  endtask
  task automatic t_external_memory_interface;
    w(HPG_ADDR_MODE, 8'hff);
    @(posedge clk);
    on <= 1'b1;
    act <= 1'b1;
    ea <= 16'h1234;
    ewd <= 8'h5c;
    @(posedge clk);
    #1 chk({pin_out[31:8], pin_out[7:5]}, {24'h5c3412, 3'b010});
    chk(pin_oe[31:24], 32'hff);
    @(posedge clk);
    mux <= 1'b1;
    ale <= 1'b1;
    @(posedge clk);
    #1 chk({pin_out[31:16], pin_out[7:5]}, {16'h3412, 3'b011});
    chk(pin_out[15:8], 32'hff);
    @(posedge clk);
    ale <= 1'b0;
    @(posedge clk);
    #1 chk(pin_out[31:24], 32'h5c);
    @(posedge clk);
    mux <= 1'b0;
    erd <= 1'b1;
    @(posedge clk);
    #1 chk({pin_oe[31:24], pin_out[7:6]}, {8'h00, 2'b10});
    @(posedge clk);
    act <= 1'b0;
    erd <= 1'b0;
    @(posedge clk);
    #1 chk(pin_out[31:24], 32'hc3);
    chk(pin_oe[31:24], 32'hff);
  endtask
  task automatic give_verdict;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1 t_reset();
    t_modes();
    t_pins();
    t_pullup();
    t_external_memory_interface();
    give_verdict();
  end
endmodule
`default_nettype wire
